// File: logic/sac_defs.svh
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH
`define SAC_CLK_HZ 10000000
`define SAC_SEC_MS 1000
`define SAC_CLEAR_MS 100
`define SAC_DOOR_MS 5000
`define SAC_FRAME_WORDS 32768
`define SAC_WDT_DUAL 15'h0008
`define SAC_WDT_SINGLE 15'h4000
`define SAC_FB_HV 8'hAF
`define SAC_FB_DISC 8'h2B
`define SAC_FB_HACK_MS 8'h04
`endif

// File: logic/sac_pkg.sv
package sac_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_WSYNC = 4'h1, ST_DISC = 4'h3, ST_STIM = 4'h2,
    ST_HACK = 4'h6, ST_HSEG = 4'h7, ST_DOOR = 4'h5, ST_HV = 4'h4,
    ST_CLEAR = 4'hC, ST_TIMERS = 4'hD, ST_ACQ = 4'hF, ST_FLUSH = 4'hE
  } seq_state_t;
  typedef enum logic [2:0] {
    OP_START_HIST = 3'h0, OP_START_LIST = 3'h1, OP_STOP = 3'h2,
    OP_SAFE = 3'h3, OP_CHECKOUT = 3'h4, OP_OTHER = 3'h5
  } cmd_op_t;
  typedef enum logic [3:0] {
    ERR_NONE = 4'h0, ERR_FORMAT = 4'h1, ERR_STATE = 4'h2,
    ERR_LOCKED = 4'h3, ERR_DOOR_POWER = 4'h4
  } err_code_t;
endpackage : sac_pkg

// File: logic/acq_buf_if.sv
`timescale 1ns/10ps
interface acq_buf_if;
  logic wr_valid;
  logic [15:0] wr_data;
  logic hist_mode;
  logic swap_req;
  logic swap_ack;
  logic clear_req;
  logic clear_done;
  logic [15:0] fill_len;
  logic full;
  logic send_busy;
  modport ctrl (output wr_valid, wr_data, hist_mode, swap_req, clear_req,
                input swap_ack, clear_done, fill_len, full, send_busy);
  modport store (input wr_valid, wr_data, hist_mode, swap_req, clear_req,
                 output swap_ack, clear_done, fill_len, full, send_busy);
endinterface : acq_buf_if

// File: logic/sync_pacer.sv
`timescale 1ns/10ps
module sync_pacer #(
  parameter int SEC_CYCLES = 10000000
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sync_pin,
  output logic tick,
  output logic internal_pacing
);
  logic s1_q, s2_q, s3_q, lost_q;
  logic [23:0] cnt_q;
  wire pps_rise = s2_q & ~s3_q;
  wire sec_up = cnt_q == 24'(SEC_CYCLES - 1);
  // Sync restarts the count, so the local second only fills gaps
  assign tick = pps_rise | sec_up;
  assign internal_pacing = lost_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      cnt_q <= 24'h000000;
      lost_q <= 1'b0;
    end else begin
      s1_q <= sync_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      cnt_q <= tick ? 24'h000000 : cnt_q + 24'h000001;
      lost_q <= pps_rise ? 1'b0 : (sec_up ? 1'b1 : lost_q);
    end
  end
endmodule : sync_pacer

// File: logic/pingpong_buffer.sv
`timescale 1ns/10ps
`include "sac_defs.svh"
module pingpong_buffer (
  input wire logic clk,
  input wire logic srst,
  acq_buf_if.store bi,
  input wire logic frame_ready,
  output logic frame_valid,
  output logic [15:0] frame_data,
  output logic frame_last,
  output logic [15:0] frame_seq
);
  localparam int FW = `SAC_FRAME_WORDS;
  logic [15:0] mem [0:2*FW-1];
  logic act_q, sbuf_q, send_q, clr_q, fv_q, fl_q;
  logic [15:0] fill_q, slen_q, sidx_q, cidx_q, fd_q, seq_q;
  wire [15:0] fw16 = 16'(FW);
  wire [15:0] fw_last = 16'(FW - 1);
  wire full = fill_q == fw16;
  wire wr_go = bi.wr_valid && (bi.hist_mode || !full) && !clr_q;
  wire [15:0] waddr = {act_q, bi.hist_mode ? bi.wr_data[14:0] : fill_q[14:0]};
  wire [15:0] raddr = {sbuf_q, sidx_q[14:0]};
  wire adv = send_q && (!fv_q || frame_ready);
  // Swap refused while the other half still drains
  wire ack = bi.swap_req && !send_q && !clr_q;
  assign bi.swap_ack = ack;
  assign bi.full = full;
  assign bi.send_busy = send_q;
  assign bi.clear_done = !clr_q;
  assign bi.fill_len = bi.hist_mode ? fw16 : fill_q;
  assign frame_valid = fv_q;
  assign frame_data = fd_q;
  assign frame_last = fl_q;
  assign frame_seq = seq_q;
  // Sent words are zeroed so a half is clean for the next histogram
  always_ff @(posedge clk) begin
    if (clr_q) begin
      mem[cidx_q] <= 16'h0000;
    end else begin
      if (wr_go) mem[waddr] <= bi.hist_mode ? mem[waddr] + 16'h0001 : bi.wr_data;
      if (adv) mem[raddr] <= 16'h0000;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      act_q <= 1'b0;
      sbuf_q <= 1'b0;
      send_q <= 1'b0;
      clr_q <= 1'b0;
      fv_q <= 1'b0;
      fl_q <= 1'b0;
      fill_q <= 16'h0000;
      slen_q <= 16'h0000;
      sidx_q <= 16'h0000;
      cidx_q <= 16'h0000;
      fd_q <= 16'h0000;
      seq_q <= 16'h0000;
    end else begin
      if (bi.clear_req) begin
        clr_q <= 1'b1;
        cidx_q <= 16'h0000;
      end else if (clr_q) begin
        cidx_q <= cidx_q + 16'h0001;
        if (cidx_q == 16'hFFFF) clr_q <= 1'b0;
      end
      if (bi.clear_req || ack) fill_q <= 16'h0000;
      else if (wr_go && !bi.hist_mode) fill_q <= fill_q + 16'h0001;
      if (ack) begin
        act_q <= ~act_q;
        send_q <= 1'b1;
        sbuf_q <= act_q;
        slen_q <= bi.fill_len;
        sidx_q <= 16'h0000;
        seq_q <= seq_q + 16'h0001;
      end
      // Whole frame always goes out, words past the used length as zero
      if (adv) begin
        fd_q <= (sidx_q < slen_q) ? mem[raddr] : 16'h0000;
        fv_q <= 1'b1;
        fl_q <= sidx_q == fw_last;
        sidx_q <= sidx_q + 16'h0001;
        if (sidx_q == fw_last) send_q <= 1'b0;
      end else if (frame_ready) begin
        fv_q <= 1'b0;
      end
    end
  end
endmodule : pingpong_buffer

// File: logic/science_acquisition_controller.sv
`timescale 1ns/10ps
`include "sac_defs.svh"
module science_acquisition_controller #(
  parameter int SEC_CYCLES = `SAC_SEC_MS * (`SAC_CLK_HZ / 1000),
  parameter int CLEAR_CYCLES = `SAC_CLEAR_MS * (`SAC_CLK_HZ / 1000),
  parameter int DOOR_CYCLES = `SAC_DOOR_MS * (`SAC_CLK_HZ / 1000)
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sync_pin,
  input wire logic wdt_expire_pin,
  input wire logic dual_supply_pin,
  input wire logic door_open_sense_pin,
  input wire logic [1:0] actuator_bus_on_pin,
  input wire logic cmd_valid,
  input wire sac_pkg::cmd_op_t cmd_op,
  input wire logic [7:0] cmd_id,
  input wire logic cmd_check_ok,
  input wire logic cmd_door_open,
  input wire logic [1:0] cmd_test_mode,
  input wire logic [7:0] discriminator_level_param,
  input wire logic stim_enable_param,
  input wire logic [7:0] hack_interval_param,
  input wire logic [127:0] hot_segment_masks,
  input wire logic [7:0] high_voltage_level_param,
  input wire logic [15:0] acquisition_timeout_param,
  input wire logic [15:0] exposure_duration_param,
  input wire logic [7:0] hv_level_now,
  input wire logic ev_valid,
  input wire logic [15:0] ev_data,
  input wire logic frame_ready,
  output logic frame_valid,
  output logic [15:0] frame_data,
  output logic frame_last,
  output logic [15:0] frame_seq,
  output logic [7:0] disc_level,
  output logic stim_on,
  output logic [7:0] hack_interval,
  output logic [127:0] hot_seg_mask,
  output logic [1:0] test_mode,
  output logic door_open_req,
  output logic door_drive,
  output logic hv_on,
  output logic [7:0] hv_level_target,
  output logic hv_no_ramp,
  output logic [3:0] hk_state,
  output logic hk_fallback,
  output logic hk_internal_pacing,
  output logic [7:0] hk_err_id,
  output logic hk_err_id_valid,
  output logic [3:0] hk_err_code,
  output logic err_log_push,
  output logic [3:0] err_log_code,
  output logic [7:0] err_log_id,
  output logic [7:0] hk_last_ok_cmd,
  output logic [15:0] hk_used_len,
  output logic hk_overrun
);
  acq_buf_if bi ();
  sac_pkg::seq_state_t st_q;
  logic tick;
  logic [4:0] pin_s1_q, pin_s2_q;
  logic wdt_s3_q, fallback_q, hist_q, door_wait_q, tout_en_q, swap_req_q;
  logic close_q, err_sec_q, err_idv_q, overrun_q, drive_q, hv_on_q, stim_q;
  logic [14:0] wdt_cnt_q;
  logic [31:0] timer_q;
  logic [15:0] tout_q, exp_q, used_q;
  logic [7:0] run_id_q, err_id_q, last_ok_q, disc_q, hack_q, hv_tgt_q;
  logic [127:0] mask_q;
  logic [1:0] test_q;
  logic door_req_q;
  sac_pkg::err_code_t err_code_q;

  sync_pacer #(.SEC_CYCLES(SEC_CYCLES)) u_pacer (
    .clk(clk),
    .srst(srst),
    .sync_pin(sync_pin),
    .tick(tick),
    .internal_pacing(hk_internal_pacing)
  );
  pingpong_buffer u_buf (
    .clk(clk),
    .srst(srst),
    .bi(bi.store),
    .frame_ready(frame_ready),
    .frame_valid(frame_valid),
    .frame_data(frame_data),
    .frame_last(frame_last),
    .frame_seq(frame_seq)
  );

  wire wdt_rise = pin_s2_q[4] & ~wdt_s3_q;
  wire door_open_s = pin_s2_q[2];
  wire power_on = |pin_s2_q[1:0];
  wire [14:0] wdt_thr = pin_s2_q[3] ? `SAC_WDT_DUAL : `SAC_WDT_SINGLE;
  wire fb_rise = !fallback_q && (wdt_cnt_q >= wdt_thr);
  wire in_acq = st_q == sac_pkg::ST_ACQ;

  // Command acceptance
  wire is_start = cmd_op == sac_pkg::OP_START_HIST || cmd_op == sac_pkg::OP_START_LIST;
  wire is_stop = cmd_op == sac_pkg::OP_STOP || cmd_op == sac_pkg::OP_SAFE
                 || cmd_op == sac_pkg::OP_CHECKOUT;
  wire rej = cmd_valid && (fallback_q || !cmd_check_ok
             || (is_start && st_q != sac_pkg::ST_IDLE));
  wire cmd_ok = cmd_valid && !rej;
  wire stop_ok = cmd_ok && is_stop && st_q != sac_pkg::ST_IDLE;
  wire safe_ok = cmd_ok && cmd_op == sac_pkg::OP_SAFE;
  wire tout_hit = tick && tout_en_q && tout_q == 16'h0001;
  wire term = stop_ok || tout_hit;
  sac_pkg::err_code_t rej_code;
  assign rej_code = fallback_q ? sac_pkg::ERR_LOCKED
                    : (!cmd_check_ok ? sac_pkg::ERR_FORMAT : sac_pkg::ERR_STATE);

  // Errors: the first in a second is reported, the rest go to the log, except a door error in the same cycle as a logged reject
  wire door_fail = st_q == sac_pkg::ST_DOOR && !door_wait_q
                   && door_open_s != door_req_q && !power_on;
  wire err_evt = rej || door_fail;
  wire err_allow = !err_sec_q || tick;
  wire err_latch = err_evt && err_allow;
  wire both_err = rej && door_fail;
  sac_pkg::err_code_t cur_code;
  assign cur_code = rej ? rej_code : sac_pkg::ERR_DOOR_POWER;
  wire [7:0] cur_id = rej ? cmd_id : run_id_q;
  assign err_log_push = (err_evt && !err_allow) || both_err;
  assign err_log_code = (both_err && err_allow) ? sac_pkg::ERR_DOOR_POWER : cur_code;
  assign err_log_id = (both_err && err_allow) ? run_id_q : cur_id;

  // Buffer control; list swaps follow the fill count, histogram swaps the exposure count of seconds
  wire list_full_evt = in_acq && !hist_q && bi.full && !swap_req_q;
  wire exp_hit = in_acq && hist_q && tick && exp_q == 16'h0001;
  wire door_move = (st_q == sac_pkg::ST_DOOR && door_wait_q) || close_q;
  assign bi.wr_valid = ev_valid && in_acq;
  assign bi.wr_data = ev_data;
  assign bi.hist_mode = hist_q;
  assign bi.swap_req = swap_req_q;
  assign bi.clear_req = st_q == sac_pkg::ST_CLEAR && !door_wait_q && !bi.send_busy;

  assign disc_level = disc_q;
  assign stim_on = stim_q;
  assign hack_interval = hack_q;
  assign hot_seg_mask = mask_q;
  assign test_mode = test_q;
  assign door_open_req = door_req_q;
  assign door_drive = drive_q;
  assign hv_on = hv_on_q;
  assign hv_level_target = hv_tgt_q;
  assign hv_no_ramp = fallback_q;
  assign hk_state = st_q;
  assign hk_fallback = fallback_q;
  assign hk_err_id = err_id_q;
  assign hk_err_id_valid = err_idv_q;
  assign hk_err_code = err_code_q;
  assign hk_last_ok_cmd = last_ok_q;
  assign hk_used_len = used_q;
  assign hk_overrun = overrun_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
      wdt_s3_q <= 1'b0;
      wdt_cnt_q <= 15'h0000;
      fallback_q <= 1'b0;
    end else begin
      pin_s1_q <= {wdt_expire_pin, dual_supply_pin, door_open_sense_pin, actuator_bus_on_pin};
      pin_s2_q <= pin_s1_q;
      wdt_s3_q <= pin_s2_q[4];
      if (wdt_rise && !fallback_q) wdt_cnt_q <= wdt_cnt_q + 15'h0001;
      // Only srst (power cycle or hardware reset) clears this
      if (fb_rise) fallback_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      err_sec_q <= 1'b0;
      err_idv_q <= 1'b0;
      err_id_q <= 8'h00;
      err_code_q <= sac_pkg::ERR_NONE;
      last_ok_q <= 8'h00;
    end else begin
      err_sec_q <= err_latch ? 1'b1 : (tick ? 1'b0 : err_sec_q);
      if (err_latch) begin
        err_code_q <= cur_code;
        err_id_q <= cur_id;
        err_idv_q <= !rej || cmd_check_ok;
      end
      if (cmd_ok) last_ok_q <= cmd_id;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= sac_pkg::ST_IDLE;
      hist_q <= 1'b0;
      door_req_q <= 1'b0;
      door_wait_q <= 1'b0;
      close_q <= 1'b0;
      drive_q <= 1'b0;
      test_q <= 2'h0;
      run_id_q <= 8'h00;
      timer_q <= 32'h00000000;
      tout_q <= 16'h0000;
      tout_en_q <= 1'b0;
      exp_q <= 16'h0000;
      swap_req_q <= 1'b0;
      overrun_q <= 1'b0;
      used_q <= 16'h0000;
      disc_q <= 8'h00;
      stim_q <= 1'b0;
      hack_q <= 8'h00;
      mask_q <= 128'h0;
      hv_on_q <= 1'b0;
      hv_tgt_q <= 8'h00;
    end else begin
      drive_q <= door_move && power_on;
      swap_req_q <= list_full_evt || exp_hit || (in_acq && term)
                    || (swap_req_q && !bi.swap_ack);
      if (list_full_evt && bi.send_busy) overrun_q <= 1'b1;
      else if (cmd_ok && is_start) overrun_q <= 1'b0;
      if (tick && tout_en_q && tout_q != 16'h0000) tout_q <= tout_q - 16'h0001;
      if (exp_hit) exp_q <= (exposure_duration_param == 16'h0000) ? 16'h0001
                            : exposure_duration_param;
      else if (tick && in_acq && hist_q) exp_q <= exp_q - 16'h0001;
      if (close_q) begin
        timer_q <= timer_q - 32'h00000001;
        if (timer_q <= 32'h00000001) close_q <= 1'b0;
      end
      if (fb_rise) begin
        // Hard-wired list acquisition, entered from any state
        st_q <= sac_pkg::ST_ACQ;
        hist_q <= 1'b0;
        tout_en_q <= 1'b0;
        close_q <= 1'b0;
        door_wait_q <= 1'b0;
        disc_q <= `SAC_FB_DISC;
        stim_q <= 1'b1;
        hack_q <= `SAC_FB_HACK_MS;
        mask_q <= 128'h0;
        hv_on_q <= 1'b1;
        hv_tgt_q <= `SAC_FB_HV;
      end else if (term) begin
        st_q <= in_acq ? sac_pkg::ST_FLUSH : sac_pkg::ST_IDLE;
        if (in_acq) used_q <= bi.fill_len;
        tout_en_q <= 1'b0;
        door_wait_q <= 1'b0;
        if (safe_ok) begin
          hv_on_q <= 1'b0;
          door_req_q <= 1'b0;
          close_q <= door_open_s && power_on;
          timer_q <= 32'(DOOR_CYCLES);
        end
      end else begin
        case (st_q)
          sac_pkg::ST_IDLE: begin
            if (cmd_ok && is_start) begin
              st_q <= sac_pkg::ST_WSYNC;
              hist_q <= cmd_op == sac_pkg::OP_START_HIST;
              door_req_q <= cmd_door_open;
              test_q <= cmd_test_mode;
              run_id_q <= cmd_id;
              close_q <= 1'b0;
            end else if (safe_ok) begin
              hv_on_q <= 1'b0;
              door_req_q <= 1'b0;
              close_q <= door_open_s && power_on;
              timer_q <= 32'(DOOR_CYCLES);
            end
          end
          sac_pkg::ST_WSYNC: if (tick) st_q <= sac_pkg::ST_DISC;
          sac_pkg::ST_DISC: begin
            disc_q <= discriminator_level_param;
            st_q <= sac_pkg::ST_STIM;
          end
          sac_pkg::ST_STIM: begin
            stim_q <= stim_enable_param;
            st_q <= sac_pkg::ST_HACK;
          end
          sac_pkg::ST_HACK: begin
            if (!hist_q) hack_q <= hack_interval_param;
            st_q <= sac_pkg::ST_HSEG;
          end
          sac_pkg::ST_HSEG: begin
            mask_q <= hot_segment_masks;
            st_q <= sac_pkg::ST_DOOR;
          end
          sac_pkg::ST_DOOR: begin
            if (!door_wait_q) begin
              // No power: the door cannot move, so the wait is skipped
              if (door_open_s == door_req_q || !power_on) begin
                st_q <= sac_pkg::ST_HV;
              end else begin
                door_wait_q <= 1'b1;
                timer_q <= 32'(DOOR_CYCLES);
              end
            end else begin
              timer_q <= timer_q - 32'h00000001;
              if (timer_q <= 32'h00000001) begin
                door_wait_q <= 1'b0;
                st_q <= sac_pkg::ST_HV;
              end
            end
          end
          sac_pkg::ST_HV: begin
            hv_on_q <= 1'b1;
            hv_tgt_q <= high_voltage_level_param;
            if (hv_on_q && hv_level_now == high_voltage_level_param) begin
              st_q <= sac_pkg::ST_CLEAR;
            end
          end
          sac_pkg::ST_CLEAR: begin
            if (!door_wait_q) begin
              if (!bi.send_busy) begin
                door_wait_q <= 1'b1;
                timer_q <= 32'(CLEAR_CYCLES);
              end
            end else if (timer_q > 32'h00000001) begin
              timer_q <= timer_q - 32'h00000001;
            end else if (bi.clear_done) begin
              door_wait_q <= 1'b0;
              st_q <= sac_pkg::ST_TIMERS;
            end
          end
          sac_pkg::ST_TIMERS: begin
            tout_q <= acquisition_timeout_param;
            tout_en_q <= acquisition_timeout_param != 16'h0000;
            exp_q <= (exposure_duration_param == 16'h0000) ? 16'h0001
                     : exposure_duration_param;
            st_q <= sac_pkg::ST_ACQ;
          end
          sac_pkg::ST_ACQ: st_q <= sac_pkg::ST_ACQ;
          sac_pkg::ST_FLUSH: if (!swap_req_q) st_q <= sac_pkg::ST_IDLE;
          default: st_q <= sac_pkg::ST_IDLE;
        endcase
      end
    end
  end

  a_fallback_sticky: assert property (@(posedge clk) disable iff (srst)
    fallback_q |=> fallback_q && st_q == sac_pkg::ST_ACQ) else $error("fallback left");
  a_fallback_lock: assert property (@(posedge clk) disable iff (srst)
    (fallback_q && cmd_valid) |=> hk_err_code == sac_pkg::ERR_LOCKED || $past(!err_allow))
    else $error("command taken in fallback");
  a_sync_start: assert property (@(posedge clk) disable iff (srst)
    (st_q == sac_pkg::ST_WSYNC && !term && !fb_rise) |=> st_q == ($past(tick) ? sac_pkg::ST_DISC
    : sac_pkg::ST_WSYNC)) else $error("startup not on sync");
  a_door_power: assert property (@(posedge clk) disable iff (srst)
    door_drive |-> $past(power_on)) else $error("door driven unpowered");
  a_hv_gate: assert property (@(posedge clk) disable iff (srst)
    (st_q == sac_pkg::ST_HV && hv_level_now != high_voltage_level_param && !term && !fb_rise)
    |=> st_q == sac_pkg::ST_HV) else $error("left HV step early");
  a_list_swap: assert property (@(posedge clk) disable iff (srst)
    list_full_evt |=> swap_req_q ##[0:2] (bi.swap_ack || bi.send_busy))
    else $error("no swap on full");
  a_err_hold: assert property (@(posedge clk) disable iff (srst)
    !err_latch |=> $stable(hk_err_code) && $stable(hk_err_id)) else $error("error changed");
  a_one_err: assert property (@(posedge clk) disable iff (srst)
    (err_sec_q && !tick) |-> !err_latch) else $error("second error in one second");
  a_err_report: assert property (@(posedge clk) disable iff (srst)
    (rej && err_allow) |=> hk_err_code == $past(rej_code) && hk_err_id == $past(cmd_id))
    else $error("reject not reported");
  a_cmd_echo: assert property (@(posedge clk) disable iff (srst)
    cmd_ok |=> hk_last_ok_cmd == $past(cmd_id)) else $error("command code lost");
  a_term_flush: assert property (@(posedge clk) disable iff (srst)
    (in_acq && term && !fb_rise) |=> st_q == sac_pkg::ST_FLUSH && swap_req_q)
    else $error("termination without flush");
endmodule : science_acquisition_controller

// File: verif/cdh_link_model.sv
`timescale 1ns/10ps
module cdh_link_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic frame_valid,
  input wire logic [15:0] frame_data,
  input wire logic frame_last,
  input wire logic hv_on,
  input wire logic [7:0] hv_level_target,
  output logic frame_ready,
  output logic [7:0] hv_level_now
);
  logic [15:0] cap [4];
  int n_words = 0;
  int last_at = -1;
  logic [1:0] stall_q = 2'h0;
  // Stalls only within the first 64 words received, so the long frame stays short enough
  assign frame_ready = !(n_words < 64 && stall_q == 2'h3);
  always_ff @(posedge clk) begin
    stall_q <= stall_q + 2'h1;
    if (srst || !hv_on) begin
      hv_level_now <= 8'h00;
    end else if (hv_level_now < hv_level_target) begin
      hv_level_now <= hv_level_now + 8'h01;
    end else if (hv_level_now > hv_level_target) begin
      hv_level_now <= hv_level_now - 8'h01;
    end
    if (frame_valid && frame_ready) begin
      if (n_words < 4) cap[n_words] <= frame_data;
      if (frame_last) last_at <= n_words;
      n_words <= n_words + 1;
    end
  end
endmodule : cdh_link_model

// File: verif/testbench.sv
`timescale 1ns/10ps
`include "sac_defs.svh"
module testbench;
  typedef struct {sac_pkg::cmd_op_t op; logic ok; logic [7:0] id; logic [3:0] err;} row_t;
  logic clk = 0, srst = 1, wdt = 0, cmd_valid = 0, cmd_ok = 1, ev_valid = 0;
  logic sync = 0, dual = 0, dsense = 0, door_open = 1, ddrive, stim, ovr;
  logic [1:0] abus = 2'h1, tmode = 2'h2;
  logic fv, fl, ready, hv_on, no_ramp, fb, ipace, idv, push, dreq;
  logic [15:0] ev_data = 16'h0000, fd, used, fseq, tout = 16'h0000, expo = 16'h0001;
  logic [7:0] cmd_id = 8'h00, hv_now, disc, hack, hvt, eid, lastok, lid, log_id;
  logic [127:0] hsm;
  logic [1:0] tm;
  logic [3:0] st, ecode, lcode, log_code;
  sac_pkg::cmd_op_t cmd_op = sac_pkg::OP_OTHER;
  int miscompares = 0, n_compared = 0, cycles = 0, pushes = 0, p0;
  row_t rows [5] = '{'{sac_pkg::OP_STOP, 1, 8'h21, 4'h0}, '{sac_pkg::OP_CHECKOUT, 1, 8'h22, 4'h0},
    '{sac_pkg::OP_SAFE, 1, 8'h23, 4'h0}, '{sac_pkg::OP_OTHER, 1, 8'h24, 4'h0},
    '{sac_pkg::OP_OTHER, 0, 8'h25, sac_pkg::ERR_FORMAT}};
  science_acquisition_controller #(.SEC_CYCLES(200), .CLEAR_CYCLES(10), .DOOR_CYCLES(20))
    science_acquisition_controller_i (.clk(clk), .srst(srst), .sync_pin(sync),
    .wdt_expire_pin(wdt), .dual_supply_pin(dual), .door_open_sense_pin(dsense),
    .actuator_bus_on_pin(abus), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_id(cmd_id),
    .cmd_check_ok(cmd_ok), .cmd_door_open(door_open), .cmd_test_mode(tmode),
    .discriminator_level_param(8'h3C), .stim_enable_param(1'b1), .hack_interval_param(8'h07),
    .hot_segment_masks({4{32'h0F0FA5A5}}), .high_voltage_level_param(8'h28),
    .acquisition_timeout_param(tout), .exposure_duration_param(expo),
    .hv_level_now(hv_now), .ev_valid(ev_valid), .ev_data(ev_data), .frame_ready(ready),
    .frame_valid(fv), .frame_data(fd), .frame_last(fl), .frame_seq(fseq), .disc_level(disc),
    .stim_on(stim), .hack_interval(hack), .hot_seg_mask(hsm), .test_mode(tm),
    .door_open_req(dreq), .door_drive(ddrive), .hv_on(hv_on), .hv_level_target(hvt),
    .hv_no_ramp(no_ramp), .hk_state(st), .hk_fallback(fb), .hk_internal_pacing(ipace),
    .hk_err_id(eid), .hk_err_id_valid(idv), .hk_err_code(ecode), .err_log_push(push),
    .err_log_code(log_code), .err_log_id(log_id), .hk_last_ok_cmd(lastok),
    .hk_used_len(used), .hk_overrun(ovr));
  cdh_link_model cdh_link_model_i (.clk(clk), .srst(srst), .frame_valid(fv), .frame_data(fd),
    .frame_last(fl), .hv_on(hv_on), .hv_level_target(hvt), .frame_ready(ready),
    .hv_level_now(hv_now));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (push === 1'b1) begin
      pushes++;
      lcode = log_code;
      lid = log_id;
    end
    if (cycles == 120000) begin
      miscompares++;
      conclude();
    end
  end
  task conclude();
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // Ends one cycle after the taking edge, where the answer stands
  task cmd(input sac_pkg::cmd_op_t op, input logic ok, input logic [7:0] id);
    @(posedge clk);
    #1 cmd_op = op;
    {cmd_ok, cmd_id, cmd_valid} = {ok, id, 1'b1};
    @(posedge clk);
    #1 cmd_valid = 0;
    @(posedge clk);
    #1;
  endtask : cmd
  task wait_st(input logic [3:0] s, input int lim);
    for (int i = 0; i < lim && st !== s; i++) @(posedge clk);
    #1 chk("hk_state", s, st);
  endtask : wait_st
  initial begin
    repeat (10) @(posedge clk);
    #1 srst = 0;
    chk("reset state", sac_pkg::ST_IDLE, st);
    chk("reset err", sac_pkg::ERR_NONE, ecode);
    foreach (rows[i]) begin
      cmd(rows[i].op, rows[i].ok, rows[i].id);
      if (rows[i].err === 4'h0) chk("last ok cmd", rows[i].id, lastok);
      else chk("err code", rows[i].err, ecode);
    end
    chk("err id valid", 1'b0, idv);
    chk("hv off", 1'b0, hv_on);
    repeat (250) @(posedge clk);
    cmd(sac_pkg::OP_START_LIST, 1, 8'h31);
    chk("wait sync", sac_pkg::ST_WSYNC, st);
    cmd(sac_pkg::OP_START_HIST, 1, 8'h32);
    chk("busy err", sac_pkg::ERR_STATE, ecode);
    chk("busy err id", 8'h32, eid);
    p0 = pushes;
    cmd(sac_pkg::OP_OTHER, 0, 8'h33);
    chk("err held", sac_pkg::ERR_STATE, ecode);
    chk("log push", p0 + 1, pushes);
    chk("log code", sac_pkg::ERR_FORMAT, lcode);
    chk("log id", 8'h33, lid);
    sync = 1;
    repeat (3) @(posedge clk);
    #1 chk("sync start", sac_pkg::ST_DISC, st);
    chk("sync pacing", 1'b0, ipace);
    wait_st(sac_pkg::ST_DOOR, 300);
    repeat (3) @(posedge clk);
    #1 chk("door wait", sac_pkg::ST_DOOR, st);
    chk("door drive", 1'b1, ddrive);
    dsense = 1;
    wait_st(sac_pkg::ST_ACQ, 70000);
    chk("stim", 1'b1, stim);
    chk("disc", 8'h3C, disc);
    chk("hack", 8'h07, hack);
    chk("masks", {4{32'h0F0FA5A5}}, hsm);
    chk("test mode", 2'h2, tm);
    chk("door req", 1'b1, dreq);
    chk("hv level", 8'h28, hv_now);
    chk("pacing", 1'b1, ipace);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      #1 {ev_valid, ev_data} = {1'b1, 16'hA5A0 + 16'(i)};
    end
    @(posedge clk);
    #1 ev_valid = 0;
    cmd(sac_pkg::OP_STOP, 1, 8'h34);
    for (int i = 0; i < 40000 && cdh_link_model_i.n_words < 32768; i++) @(posedge clk);
    #1 chk("frame words", 32768, cdh_link_model_i.n_words);
    for (int i = 0; i < 4; i++) chk("word", i < 3 ? 16'hA5A0 + i : 0, cdh_link_model_i.cap[i]);
    chk("last word", 32767, cdh_link_model_i.last_at);
    chk("used len", 16'h0003, used);
    chk("frame seq", 16'h0001, fseq);
    chk("overrun", 1'b0, ovr);
    chk("stopped", sac_pkg::ST_IDLE, st);
    abus = 2'h0;
    repeat (2) @(posedge clk);
    cmd(sac_pkg::OP_SAFE, 1, 8'h36);
    chk("hv safe", 1'b0, hv_on);
    chk("no power drive", 1'b0, ddrive);
    abus = 2'h2;
    repeat (2) @(posedge clk);
    cmd(sac_pkg::OP_SAFE, 1, 8'h37);
    chk("door close", 1'b1, ddrive);
    repeat (8) begin
      @(posedge clk);
      #1 wdt = 1;
      repeat (3) @(posedge clk);
      #1 wdt = 0;
      repeat (3) @(posedge clk);
    end
    #1 chk("single supply", 1'b0, fb);
    dual = 1;
    wait_st(sac_pkg::ST_ACQ, 20);
    chk("fallback", 1'b1, fb);
    chk("no ramp", 1'b1, no_ramp);
    chk("fb hv", `SAC_FB_HV, hvt);
    chk("fb disc", `SAC_FB_DISC, disc);
    repeat (250) @(posedge clk);
    cmd(sac_pkg::OP_STOP, 1, 8'h35);
    chk("locked", sac_pkg::ERR_LOCKED, ecode);
    chk("still acq", sac_pkg::ST_ACQ, st);
    conclude();
  end
endmodule : testbench
